// file: inc/sl_pkg.sv
`default_nettype none
package sl_pkg;
    localparam int LANES = 3;
    localparam int SLOTS = 7;
    localparam int WORD_W = LANES * SLOTS;
    localparam int CLK_MHZ = 50;
    // serial slot length in system clocks, and where in the slot the receiver samples
    localparam int SLOT_CYC = 1;
    localparam int SAMPLE_OFS = SLOT_CYC / 2;
    // forwarded clock lane is high for the first slots of a frame
    localparam int CLK_HIGH_SLOTS = 4;
    // strobe stays low this long after new data, then rises mid-frame
    localparam int STROBE_LOW_CYC = (SLOTS * SLOT_CYC + 1) / 2;
    localparam int FIFO_DEPTH = 16;
    localparam int LOCK_MS = 10;
    localparam int LOCK_CYC = LOCK_MS * 1000 * CLK_MHZ;
    localparam int TX_PD_NS = 100;
    localparam int TX_PD_CYC = TX_PD_NS * CLK_MHZ / 1000;
    localparam int RX_PD_US = 1;
    localparam int RX_PD_CYC = RX_PD_US * CLK_MHZ;
    typedef enum logic {SL_IDLE, SL_SEND} sl_tx_state_t;
endpackage
`default_nettype wire

// file: hw/sl_sync.sv
`default_nettype none
module sl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule
`default_nettype wire

// file: hw/sl_fifo.sv
`default_nettype none
module sl_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// file: hw/sl_link.sv
// Behaviour
// - transmitter captures all 21 bits every locked clock rise while the buffer has room
// - seven serial slots per lane per period
// - exactly three serial data lanes carry word
// - frame clock forwarded on a fourth lane
// - transmitter power-down floats serial outputs, stops
// - receiver power-down forces parallel outputs low
// - receiver power-down entry within one microsecond
// - receiver lock within 10 ms; words ignored before
// - receiver samples each bit slot in sequence
// - strobe clock runs at forwarded frame rate
// - transmitter lock within 10 ms; early data invalid
// - transmitter outputs float within 100 ns
// - outputs stable at the strobe rising edge
`default_nettype none
module sl_link #(
    parameter int unsigned LOCK_CYC = sl_pkg::LOCK_CYC,
    parameter int DEPTH = sl_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic tx_parallel_clock_in,
    input wire logic [sl_pkg::WORD_W-1:0] parallel_tx_inputs,
    input wire logic tx_power_down_n,
    output logic [sl_pkg::LANES-1:0] serial_data_lanes_out,
    output logic serial_data_lanes_oe_n,
    output logic forwarded_clock_lane_out,
    output logic forwarded_clock_lane_oe_n,
    output logic tx_fifo_ready,
    output logic tx_locked,
    input wire logic forwarded_clock_lane_in,
    input wire logic [sl_pkg::LANES-1:0] serial_data_lanes_in,
    input wire logic rx_power_down_n,
    output logic [sl_pkg::WORD_W-1:0] parallel_rx_outputs,
    output logic rx_strobe_clock_out,
    output logic rx_locked
);
    localparam int W = sl_pkg::WORD_W;
    localparam int LW = $clog2(LOCK_CYC + 1);
    localparam int SCW = $clog2(sl_pkg::SLOT_CYC + 1);
    localparam int STW = $clog2(sl_pkg::STROBE_LOW_CYC + 1);

    // one fixed lane/slot to word bit map, shared by both directions
    function automatic logic [4:0] bit_idx(input int lane, input logic [2:0] slot);
        bit_idx = 5'(lane * sl_pkg::SLOTS) + 5'(slot);
    endfunction

    function automatic logic [LW-1:0] lock_next(input logic [LW-1:0] cnt);
        lock_next = (cnt == LW'(LOCK_CYC)) ? cnt : cnt + 1'b1;
    endfunction

    // ---------------- transmit side ----------------
    logic [W-1:0] tx_data_s, fifo_out_data, tx_word_q;
    logic tx_clk_s, tx_pd_n_s, tx_clk_prev_q, tx_rise, tx_seen_q, tx_locked_q;
    logic [LW-1:0] tx_lock_cnt_q;
    logic push_valid, fifo_out_valid, fifo_out_ready, tx_slot_end, tx_frame_end;
    sl_pkg::sl_tx_state_t tx_state_q;
    logic [2:0] tx_slot_q;
    logic [SCW-1:0] tx_sub_q;
    logic [sl_pkg::LANES-1:0] lanes_q;
    logic fclk_q, oe_n_q, tx_load_q;

    sl_sync #(.WIDTH(W + 2)) u_tx_sync (
        .clock(clock),
        .srst(srst),
        .din({parallel_tx_inputs, tx_parallel_clock_in, tx_power_down_n}),
        .dout({tx_data_s, tx_clk_s, tx_pd_n_s})
    );

    assign tx_rise = tx_clk_s & ~tx_clk_prev_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            tx_clk_prev_q <= 1'b0;
        end else begin
            tx_clk_prev_q <= tx_clk_s;
        end
    end

    // lock count restarts whenever the input clock is lost to power-down
    always_ff @(posedge clock) begin
        if (srst || !tx_pd_n_s) begin
            tx_seen_q <= 1'b0;
            tx_lock_cnt_q <= '0;
            tx_locked_q <= 1'b0;
        end else begin
            if (tx_rise) begin
                tx_seen_q <= 1'b1;
            end
            if (tx_seen_q) begin
                tx_lock_cnt_q <= lock_next(tx_lock_cnt_q);
            end
            tx_locked_q <= tx_seen_q && (tx_lock_cnt_q == LW'(LOCK_CYC));
        end
    end

    // words from before lock are never sent; a full buffer drops the word
    assign push_valid = tx_rise & tx_locked_q & tx_pd_n_s;

    sl_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_tx_fifo (
        .clock(clock),
        .srst(srst | ~tx_pd_n_s),
        .in_valid(push_valid),
        .in_ready(tx_fifo_ready),
        .in_data(tx_data_s),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    assign tx_slot_end = (tx_sub_q == SCW'(sl_pkg::SLOT_CYC - 1));
    assign tx_frame_end = tx_slot_end && (tx_slot_q == 3'(sl_pkg::SLOTS - 1));
    assign fifo_out_ready = tx_pd_n_s &&
        ((tx_state_q == sl_pkg::SL_IDLE) || (tx_state_q == sl_pkg::SL_SEND && tx_frame_end));

    always_ff @(posedge clock) begin
        if (srst || !tx_pd_n_s) begin
            tx_state_q <= sl_pkg::SL_IDLE;
            tx_word_q <= '0;
            tx_slot_q <= '0;
            tx_sub_q <= '0;
            lanes_q <= '0;
            fclk_q <= 1'b0;
            tx_load_q <= 1'b0;
        end else begin
            tx_load_q <= 1'b0;
            case (tx_state_q)
                sl_pkg::SL_IDLE, sl_pkg::SL_SEND: begin
                    if (fifo_out_valid && fifo_out_ready) begin
                        tx_state_q <= sl_pkg::SL_SEND;
                        tx_word_q <= fifo_out_data;
                        tx_slot_q <= '0;
                        tx_sub_q <= '0;
                        tx_load_q <= 1'b1;
                        fclk_q <= 1'b1;
                        for (int l = 0; l < sl_pkg::LANES; l++) begin
                            lanes_q[l] <= fifo_out_data[bit_idx(l, 3'd0)];
                        end
                    end else if (tx_state_q == sl_pkg::SL_SEND && tx_frame_end) begin
                        tx_state_q <= sl_pkg::SL_IDLE;
                        fclk_q <= 1'b0;
                        lanes_q <= '0;
                    end else if (tx_state_q == sl_pkg::SL_SEND && tx_slot_end) begin
                        tx_sub_q <= '0;
                        tx_slot_q <= tx_slot_q + 1'b1;
                        fclk_q <= (tx_slot_q + 1'b1) < 3'(sl_pkg::CLK_HIGH_SLOTS);
                        for (int l = 0; l < sl_pkg::LANES; l++) begin
                            lanes_q[l] <= tx_word_q[bit_idx(l, tx_slot_q + 1'b1)];
                        end
                    end else if (tx_state_q == sl_pkg::SL_SEND) begin
                        tx_sub_q <= tx_sub_q + 1'b1;
                    end
                end
                default: begin
                    tx_state_q <= sl_pkg::SL_IDLE;
                end
            endcase
        end
    end

    // two sync stages plus this flop keep the float well inside 100 ns
    always_ff @(posedge clock) begin
        if (srst) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= ~tx_pd_n_s;
        end
    end

    assign serial_data_lanes_out = lanes_q;
    assign forwarded_clock_lane_out = fclk_q;
    assign serial_data_lanes_oe_n = oe_n_q;
    assign forwarded_clock_lane_oe_n = oe_n_q;
    assign tx_locked = tx_locked_q;

    // ---------------- receive side ----------------
    logic rx_clk_s, rx_pd_n_s, rx_clk_prev_q, rx_rise, rx_seen_q, rx_locked_q, rx_active_q;
    logic [sl_pkg::LANES-1:0] rx_lanes_s;
    logic [LW-1:0] rx_lock_cnt_q;
    logic [2:0] rx_slot_q, cur_slot;
    logic [SCW-1:0] rx_sub_q, cur_sub;
    logic [W-1:0] acc_q, rx_out_q;
    logic rx_sample, done_q, upd_q, strobe_q;
    logic [STW-1:0] strobe_cnt_q;

    sl_sync #(.WIDTH(sl_pkg::LANES + 2)) u_rx_sync (
        .clock(clock),
        .srst(srst),
        .din({serial_data_lanes_in, forwarded_clock_lane_in, rx_power_down_n}),
        .dout({rx_lanes_s, rx_clk_s, rx_pd_n_s})
    );

    assign rx_rise = rx_clk_s & ~rx_clk_prev_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            rx_clk_prev_q <= 1'b0;
        end else begin
            rx_clk_prev_q <= rx_clk_s;
        end
    end

    always_ff @(posedge clock) begin
        if (srst || !rx_pd_n_s) begin
            rx_seen_q <= 1'b0;
            rx_lock_cnt_q <= '0;
            rx_locked_q <= 1'b0;
        end else begin
            if (rx_rise) begin
                rx_seen_q <= 1'b1;
            end
            if (rx_seen_q) begin
                rx_lock_cnt_q <= lock_next(rx_lock_cnt_q);
            end
            rx_locked_q <= rx_seen_q && (rx_lock_cnt_q == LW'(LOCK_CYC));
        end
    end

    // clock and lanes share the same sync delay, so slot 0 is present at the edge
    assign cur_slot = rx_rise ? 3'd0 : rx_slot_q;
    assign cur_sub = rx_rise ? '0 : rx_sub_q;
    assign rx_sample = (rx_rise || rx_active_q) && (cur_sub == SCW'(sl_pkg::SAMPLE_OFS));

    always_ff @(posedge clock) begin
        if (srst || !rx_pd_n_s) begin
            rx_active_q <= 1'b0;
            rx_slot_q <= '0;
            rx_sub_q <= '0;
            acc_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (rx_rise || rx_active_q) begin
                if (rx_sample) begin
                    for (int l = 0; l < sl_pkg::LANES; l++) begin
                        acc_q[bit_idx(l, cur_slot)] <= rx_lanes_s[l];
                    end
                end
                if (cur_sub == SCW'(sl_pkg::SLOT_CYC - 1)) begin
                    rx_sub_q <= '0;
                    rx_slot_q <= cur_slot + 1'b1;
                    if (cur_slot == 3'(sl_pkg::SLOTS - 1)) begin
                        rx_active_q <= 1'b0;
                        done_q <= 1'b1;
                    end else begin
                        rx_active_q <= 1'b1;
                    end
                end else begin
                    rx_sub_q <= cur_sub + 1'b1;
                    rx_slot_q <= cur_slot;
                    rx_active_q <= 1'b1;
                end
            end
        end
    end

    // outputs change with the strobe low; it rises mid-frame so data has settled
    always_ff @(posedge clock) begin
        if (srst || !rx_pd_n_s) begin
            rx_out_q <= '0;
            strobe_q <= 1'b0;
            strobe_cnt_q <= '0;
            upd_q <= 1'b0;
        end else begin
            upd_q <= 1'b0;
            if (done_q && rx_locked_q) begin
                rx_out_q <= acc_q;
                strobe_q <= 1'b0;
                strobe_cnt_q <= STW'(sl_pkg::STROBE_LOW_CYC);
                upd_q <= 1'b1;
            end else if (strobe_cnt_q != '0) begin
                strobe_cnt_q <= strobe_cnt_q - 1'b1;
                strobe_q <= (strobe_cnt_q == STW'(1));
            end
        end
    end

    assign parallel_rx_outputs = rx_out_q;
    assign rx_strobe_clock_out = strobe_q;
    assign rx_locked = rx_locked_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_tx_float_delay: assert property (
        (!tx_power_down_n)[*5] |-> serial_data_lanes_oe_n && forwarded_clock_lane_oe_n)
        else $error("serial outputs not floated within 100 ns");
    a_tx_pd_quiet: assert property (
        serial_data_lanes_oe_n |-> tx_state_q == sl_pkg::SL_IDLE || $past(tx_pd_n_s))
        else $error("transmitter still sending in power-down");
    a_rx_pd_low: assert property (
        (!rx_power_down_n)[*4] |-> parallel_rx_outputs == '0 && !rx_strobe_clock_out)
        else $error("receiver outputs not low in power-down");
    a_rx_pd_entry: assert property (
        $fell(rx_power_down_n) |-> ##[1:50] parallel_rx_outputs == '0)
        else $error("receiver power-down entry too slow");
    a_tx_capture_word: assert property (
        tx_rise && tx_locked_q && tx_pd_n_s && tx_fifo_ready |=> fifo_out_valid)
        else $error("locked input clock edge not captured");
    a_fwd_clock_shape: assert property (
        tx_load_q |-> fclk_q [*4] ##1 !fclk_q [*3])
        else $error("forwarded clock lane shape wrong");
    a_lane_slot_map: assert property (
        tx_load_q |-> lanes_q == {tx_word_q[14], tx_word_q[7], tx_word_q[0]})
        else $error("slot 0 lane mapping wrong");
    a_slot_advance: assert property (
        tx_state_q == sl_pkg::SL_SEND && !tx_frame_end && tx_slot_end |=>
        lanes_q == {tx_word_q[bit_idx(2, tx_slot_q)], tx_word_q[bit_idx(1, tx_slot_q)],
            tx_word_q[bit_idx(0, tx_slot_q)]})
        else $error("serial slot order wrong");
    a_rx_frame_align: assert property (
        rx_rise && rx_pd_n_s ##1 (!rx_rise && rx_pd_n_s)[*6] |=> done_q)
        else $error("frame not sliced from forwarded clock edge");
    a_rx_lock_gate: assert property (
        done_q && !rx_locked_q |=> $stable(parallel_rx_outputs) || parallel_rx_outputs == '0)
        else $error("word delivered before lock");
    a_strobe_setup: assert property (
        upd_q && rx_pd_n_s && !done_q ##1 (rx_pd_n_s && !done_q)[*3] |->
        !rx_strobe_clock_out ##0 $stable(parallel_rx_outputs))
        else $error("strobe rose before data settled");
    a_no_early_send: assert property (
        !tx_locked_q |=> !$rose(fifo_out_valid))
        else $error("word queued before transmitter lock");

    c_frame_sent: cover property (tx_load_q ##7 tx_load_q);
    c_word_delivered: cover property (upd_q ##[1:8] rx_strobe_clock_out);
    c_tx_powerdown: cover property ($rose(serial_data_lanes_oe_n));
    c_rx_powerdown: cover property ($fell(rx_power_down_n) ##4 parallel_rx_outputs == '0);
endmodule
`default_nettype wire

// file: tb/sl_partner.sv
`default_nettype none
module sl_partner (
    input wire logic clock,
    input wire logic rx_strobe_clock_out,
    input wire logic rx_locked,
    input wire logic [sl_pkg::WORD_W-1:0] parallel_rx_outputs,
    output logic tx_parallel_clock_in,
    output logic [sl_pkg::WORD_W-1:0] parallel_tx_inputs
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [sl_pkg::WORD_W-1:0] rx_q[$];
    time st_q[$];
    initial begin
        tx_parallel_clock_in = 1'b0;
        parallel_tx_inputs = '0;
    end
    // one new word per rising edge; the clock stands low between words
    task automatic send(input logic [sl_pkg::WORD_W-1:0] w, input int half);
        @(posedge clock);
        #1 parallel_tx_inputs = w;
        repeat (half - 1) @(posedge clock);
        #1 tx_parallel_clock_in = 1'b1;
        repeat (half) @(posedge clock);
        #1 tx_parallel_clock_in = 1'b0;
    endtask
    // words before lock are noise to the sink, so they never enter the queue
    always @(posedge rx_strobe_clock_out) begin
        if (rx_locked === 1'b1) begin
            rx_q.push_back(parallel_rx_outputs);
            st_q.push_back($time);
        end
    end
endmodule
`default_nettype wire

// file: tb/sl_link_tb_top.sv
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module sl_link_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int W = sl_pkg::WORD_W;
    localparam int L = sl_pkg::LANES;
    localparam int LK = 20;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic tx_power_down_n = 1'b1;
    logic rx_power_down_n = 1'b1;
    logic saw_full = 1'b0;
    logic tcin, fclk_o, fclk_oe_n, dat_oe_n, fifo_rdy, tx_lk, rx_lk, strobe;
    logic [W-1:0] tx_word, rx_word;
    logic [L-1:0] lanes_o;
    int n_mismatch = 0;
    int cmp_count = 0;
    // released data lanes read all ones, the inverse of their cleared level, never a clean copy
    wire [L-1:0] lanes_i = dat_oe_n ? ~lanes_o : lanes_o;
    // a released clock lane has no edges, so it reads as low
    wire fclk_i = fclk_oe_n ? 1'b0 : fclk_o;
    initial begin
        forever #10 clock = ~clock;
    end
    always @(posedge clock) if (fifo_rdy === 1'b0) saw_full <= 1'b1;
    sl_link #(.LOCK_CYC(LK)) i_dut (
        .clock(clock),
        .srst(srst),
        .tx_parallel_clock_in(tcin),
        .parallel_tx_inputs(tx_word),
        .tx_power_down_n(tx_power_down_n),
        .serial_data_lanes_out(lanes_o),
        .serial_data_lanes_oe_n(dat_oe_n),
        .forwarded_clock_lane_out(fclk_o),
        .forwarded_clock_lane_oe_n(fclk_oe_n),
        .tx_fifo_ready(fifo_rdy),
        .tx_locked(tx_lk),
        .forwarded_clock_lane_in(fclk_i),
        .serial_data_lanes_in(lanes_i),
        .rx_power_down_n(rx_power_down_n),
        .parallel_rx_outputs(rx_word),
        .rx_strobe_clock_out(strobe),
        .rx_locked(rx_lk)
    );
    sl_partner i_part (
        .clock(clock),
        .rx_strobe_clock_out(strobe),
        .rx_locked(rx_lk),
        .parallel_rx_outputs(rx_word),
        .tx_parallel_clock_in(tcin),
        .parallel_tx_inputs(tx_word)
    );
    task automatic summarize;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic get_word(output logic [W-1:0] w);
        int i;
        for (i = 0; i < 200 && i_part.rx_q.size() == 0; i++) cyc(1);
        w = (i_part.rx_q.size() > 0) ? i_part.rx_q.pop_front() : 'x;
    endtask
    task automatic relock;
        for (int i = 0; i < 12 && !(tx_lk && rx_lk); i++) i_part.send(21'h0, 4);
        `CHK("tx_locked", 1'b1, tx_lk)
        `CHK("rx_locked", 1'b1, rx_lk)
        cyc(20);
        i_part.rx_q.delete();
        i_part.st_q.delete();
    endtask
    task automatic t_reset;
        cyc(1);
        `CHK("lane oe_n", 1'b1, dat_oe_n)
        `CHK("clk oe_n", 1'b1, fclk_oe_n)
        `CHK("rx word", 21'h0, rx_word)
        `CHK("tx_locked", 1'b0, tx_lk)
        `CHK("rx_locked", 1'b0, rx_lk)
        `CHK("fifo ready", 1'b1, fifo_rdy)
    endtask
    task automatic t_early;
        int hi;
        hi = 0;
        fork
            i_part.send(21'h1fffff, 4);
            repeat (16) begin
                @(posedge clock);
                #1 hi += int'(fclk_o === 1'b1);
            end
        join
        `CHK("early frame", 0, hi)
        relock();
    endtask
    task automatic t_wire(input logic [W-1:0] w);
        logic [W-1:0] got;
        int i;
        i_part.send(w, 4);
        for (i = 0; i < 20 && fclk_o !== 1'b1; i++) cyc(1);
        for (int s = 0; s < sl_pkg::SLOTS; s++) begin
            `CHK("clock lane", s < sl_pkg::CLK_HIGH_SLOTS, fclk_o)
            for (int l = 0; l < L; l++) `CHK("data lane", w[l*7+s], lanes_o[l])
            `CHK("lane oe_n", 1'b0, dat_oe_n)
            cyc(1);
        end
        `CHK("frame end", 1'b0, fclk_o)
        get_word(got);
        `CHK("rx word", w, got)
    endtask
    task automatic t_stream;
        logic [W-1:0] got;
        i_part.rx_q.delete();
        i_part.st_q.delete();
        for (int k = 0; k < 6; k++) i_part.send(21'h0b1234 + k * 21'h04a5, 4);
        cyc(40);
        for (int k = 1; k < 6; k++) `CHK("strobe period", 160, i_part.st_q[k] - i_part.st_q[k-1])
        for (int k = 0; k < 6; k++) begin
            get_word(got);
            `CHK("stream word", 21'h0b1234 + k * 21'h04a5, got)
        end
    endtask
    // source outruns the lanes, so the buffer must refuse and later drain
    task automatic t_fill;
        logic [W-1:0] got, exp;
        int n;
        saw_full = 1'b0;
        for (int k = 0; k < 60; k++) i_part.send(21'h100 + k, 2);
        cyc(300);
        `CHK("fifo refused", 1'b1, saw_full)
        `CHK("fifo drained", 1'b1, fifo_rdy)
        n = i_part.rx_q.size();
        exp = 21'h100;
        for (int k = 0; k < n; k++) begin
            got = i_part.rx_q.pop_front();
            while (exp < got && exp < 21'h13c) exp++;
            `CHK("fill order", exp, got)
            exp++;
        end
        `CHK("fill count", 1'b1, n >= sl_pkg::FIFO_DEPTH && n < 60)
    endtask
    task automatic t_rx_pd;
        int i;
        i_part.send(21'h0c3a5f, 4);
        cyc(30);
        `CHK("rx word", 21'h0c3a5f, rx_word)
        rx_power_down_n = 1'b0;
        for (i = 0; i < sl_pkg::RX_PD_CYC && rx_word !== 21'h0; i++) cyc(1);
        `CHK("rx pd entry", 21'h0, rx_word)
        i_part.send(21'h1ffff0, 4);
        cyc(30);
        `CHK("rx pd hold", 21'h0, rx_word)
        `CHK("rx pd strobe", 1'b0, strobe)
        rx_power_down_n = 1'b1;
        relock();
        t_wire(21'h0e1d2c);
    endtask
    task automatic t_tx_pd;
        int i, hi;
        tx_power_down_n = 1'b0;
        for (i = 0; i < sl_pkg::TX_PD_CYC && dat_oe_n !== 1'b1; i++) cyc(1);
        `CHK("tx pd oe_n", 1'b1, dat_oe_n)
        `CHK("tx pd clk oe_n", 1'b1, fclk_oe_n)
        hi = 0;
        fork
            i_part.send(21'h155555, 4);
            repeat (16) begin
                @(posedge clock);
                #1 hi += int'(dat_oe_n !== 1'b1 || fclk_o === 1'b1);
            end
        join
        `CHK("tx pd silent", 0, hi)
        tx_power_down_n = 1'b1;
        relock();
        t_wire(21'h0a5a5a);
    endtask
    initial begin
        #400_000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clock);
        #1 srst = 1'b0;
        t_reset();
        t_early();
        t_wire(21'h000001);
        t_wire(21'h1f80fe);
        t_wire(21'h15a5c3);
        t_stream();
        t_fill();
        t_rx_pd();
        t_tx_pd();
        summarize();
    end
endmodule
`undef CHK
`default_nettype wire
